// ### core/input_converter_pkg.sv
`default_nettype none
package input_converter_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int WORD_W = 30;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_LAST = 5'h1D;   // Thirtieth bit index
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 30'h00000000;

  // ****************************************************************
  // Clocks and serial rates
  // ****************************************************************
  localparam longint SYS_CLK_HZ = 40000000;
  localparam longint INT_CLK_HZ = 2500000;
  localparam longint MIN_RATE_BPS = 8;
  localparam longint MAX_RATE_BPS = 256000;
  // Shortest bit period in system cycles; bit clock high and low each need >= 2
  localparam longint MIN_BIT_CYCLES = SYS_CLK_HZ / MAX_RATE_BPS;

  // ****************************************************************
  // Source select codes
  // ****************************************************************
  localparam logic [1:0] SRC_CMD_DECODER = 2'h0;
  localparam logic [1:0] SRC_SIG_PROC = 2'h1;
  localparam logic [1:0] SRC_IFACE_UNIT = 2'h2;

  // ****************************************************************
  // Synchronised vector layout
  // ****************************************************************
  localparam int SYNC_W = 5;
  localparam int SY_DATA = 0;
  localparam int SY_BITCLK = 1;
  localparam int SY_IE = 2;
  localparam int SY_IACK = 3;
  localparam int SY_RACK = 4;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h00;

  // ****************************************************************
  // Host handshake states
  // ****************************************************************
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_WAIT_IE,
    HS_INTR,
    HS_REQ,
    HS_ACK_LOW
  } hs_state_t;

endpackage : input_converter_pkg
`default_nettype wire

// ### core/pin_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// Agreed levels of the asynchronous pins, carried to the converter core
interface pin_sync_if;
  logic [input_converter_pkg::SYNC_W-1:0] level;

  modport producer (output level);
  modport consumer (input level);
endinterface : pin_sync_if
`default_nettype wire

// ### core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pinIn,
  pin_sync_if.producer sync
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;
  logic [W-1:0] level_r;
  wire [W-1:0] agree;
  wire [W-1:0] level_nxt;

  // Stage one feeds stage two only; a change counts once stages two and three agree
  assign agree = ~(stage2_r ^ stage3_r);
  assign level_nxt = (agree & stage2_r) | (~agree & level_r);

  // Three-flop chain plus the accepted level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      level_r <= '0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r <= level_nxt;
    end
  end

  assign sync.level = level_r;

endmodule : pin_sync
`default_nettype wire

// ### core/input_converter.sv
`timescale 1ns/1ps
`default_nettype none
module input_converter (
  input wire logic clk,
  input wire logic sys_rst,
  // Source choice, held steady by the user
  input wire logic [1:0] sourceSelect,
  // Serial sources, each with its own bit clock
  input wire logic cmdDecoderData,
  input wire logic cmdDecoderClk,
  input wire logic sigProcData,
  input wire logic sigProcClk,
  input wire logic ifaceUnitData,
  input wire logic ifaceUnitClk,
  // Host parallel input channel
  input wire logic hostIntrEnable,
  input wire logic hostIntrAck,
  input wire logic hostReadAck,
  output logic hostIntr,
  output logic wordReadyRequest,
  output logic [input_converter_pkg::WORD_W-1:0] hostData,
  // Diagnostics
  output logic wordOverrun
);

  // ****************************************************************
  // Source selection
  // ****************************************************************

  wire selData;
  wire selClk;
  wire isCmd;
  wire isSig;
  wire isIfu;

  // Unused select code gives a quiet line with no bit clock
  assign isCmd = (sourceSelect == input_converter_pkg::SRC_CMD_DECODER);
  assign isSig = (sourceSelect == input_converter_pkg::SRC_SIG_PROC);
  assign isIfu = (sourceSelect == input_converter_pkg::SRC_IFACE_UNIT);
  assign selData = (isCmd & cmdDecoderData) | (isSig & sigProcData) | (isIfu & ifaceUnitData);
  assign selClk = (isCmd & cmdDecoderClk) | (isSig & sigProcClk) | (isIfu & ifaceUnitClk);

  // ****************************************************************
  // Reclocking of all asynchronous inputs
  // ****************************************************************

  wire [input_converter_pkg::SYNC_W-1:0] rawPins;
  pin_sync_if syncBus ();

  // Pack data, bit clock and host handshake lines for the synchroniser
  assign rawPins[input_converter_pkg::SY_DATA] = selData;
  assign rawPins[input_converter_pkg::SY_BITCLK] = selClk;
  assign rawPins[input_converter_pkg::SY_IE] = hostIntrEnable;
  assign rawPins[input_converter_pkg::SY_IACK] = hostIntrAck;
  assign rawPins[input_converter_pkg::SY_RACK] = hostReadAck;

  // Data and bit clock pass together so their skew stays one cycle at most
  pin_sync #(
    .W(input_converter_pkg::SYNC_W)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(rawPins),
    .sync(syncBus.producer)
  );

  wire dataLvl;
  wire bitClkLvl;
  wire ieLvl;
  wire iackLvl;
  wire rackLvl;

  assign dataLvl = syncBus.level[input_converter_pkg::SY_DATA];
  assign bitClkLvl = syncBus.level[input_converter_pkg::SY_BITCLK];
  assign ieLvl = syncBus.level[input_converter_pkg::SY_IE];
  assign iackLvl = syncBus.level[input_converter_pkg::SY_IACK];
  assign rackLvl = syncBus.level[input_converter_pkg::SY_RACK];

  // ****************************************************************
  // Bit clock edge detection
  // ****************************************************************

  logic bitClkPrev_r;
  wire bitEdge;

  // Rising bit clock marks a valid data bit
  // Each bit clock phase must last two cycles to pass the agree filter,
  // which leaves the slowest to fastest source rates far inside that limit
  assign bitEdge = bitClkLvl & ~bitClkPrev_r;

  // Previous bit clock level; idle low matches the quiet line after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bitClkPrev_r <= 1'b0;
    end else begin
      bitClkPrev_r <= bitClkLvl;
    end
  end

  // ****************************************************************
  // Shift register and bit counter
  // ****************************************************************

  logic [input_converter_pkg::WORD_W-1:0] shift_r;
  logic [input_converter_pkg::CNT_W-1:0] bitCount_r;
  wire [input_converter_pkg::WORD_W-1:0] shift_nxt;
  wire [input_converter_pkg::CNT_W-1:0] bitCount_nxt;
  wire wordDone;

  // First bit received ends up in the top bit of the word
  assign shift_nxt = {shift_r[input_converter_pkg::WORD_W-2:0], dataLvl};
  assign wordDone = bitEdge & (bitCount_r == input_converter_pkg::WORD_LAST);
  assign bitCount_nxt = wordDone ? input_converter_pkg::CNT_RESET : bitCount_r + 5'h01;

  // Counter and shifter advance on bit clock edges only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= input_converter_pkg::WORD_RESET;
      bitCount_r <= input_converter_pkg::CNT_RESET;
    end else if (bitEdge) begin
      shift_r <= shift_nxt;
      bitCount_r <= bitCount_nxt;
    end
  end

  // ****************************************************************
  // Store one
  // ****************************************************************

  logic [input_converter_pkg::WORD_W-1:0] store1_r;

  // Copy in the same cycle as the last bit, well inside any bit period
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      store1_r <= input_converter_pkg::WORD_RESET;
    end else if (wordDone) begin
      store1_r <= shift_nxt;
    end
  end

  // ****************************************************************
  // Handshake state and store two control
  // ****************************************************************

  input_converter_pkg::hs_state_t hsState_r;
  input_converter_pkg::hs_state_t hsState_nxt;
  logic pending_r;
  logic fresh_r;
  logic [input_converter_pkg::WORD_W-1:0] store2_r;
  logic overrun_r;
  wire busy;
  wire ackDone;
  wire loadDirect;
  wire loadPending;
  wire loadStore2;
  wire inIdle;
  wire inReq;
  wire inAckLow;
  wire holdWord;
  wire freshClear;

  // State decodes shared by store control and the sequencer
  assign inIdle = (hsState_r == input_converter_pkg::HS_IDLE);
  assign inReq = (hsState_r == input_converter_pkg::HS_REQ);
  assign inAckLow = (hsState_r == input_converter_pkg::HS_ACK_LOW);

  // A readout runs from the interrupt decision until the acknowledge is seen
  assign busy = ~inIdle & ~inAckLow;
  assign ackDone = inReq & rackLvl;
  assign loadDirect = wordDone & ~busy;
  // A held word goes over once the readout finishes; a new word arriving then is newer
  assign loadPending = pending_r & ~busy & ~wordDone;
  assign loadStore2 = loadDirect | loadPending;
  // A word that lands mid-readout waits in store one
  assign holdWord = wordDone & busy;
  // Fresh flag is spent as the sequencer leaves idle for it
  assign freshClear = inIdle & fresh_r;

  // Store two feeds the host lines and is frozen while a readout runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      store2_r <= input_converter_pkg::WORD_RESET;
    end else if (loadDirect) begin
      store2_r <= shift_nxt;
    end else if (loadPending) begin
      store2_r <= store1_r;
    end
  end

  // Word waiting in store one; a new word wins over the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending_r <= 1'b0;
    end else if (holdWord) begin
      pending_r <= 1'b1;
    end else if (loadStore2) begin
      pending_r <= 1'b0;
    end
  end

  // Store two holds a word whose readout the sequencer has not yet started
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fresh_r <= 1'b0;
    end else if (loadStore2) begin
      fresh_r <= 1'b1;
    end else if (freshClear) begin
      fresh_r <= 1'b0;
    end
  end

  // Sticky flag: store one overwritten mid-readout before its word reached the host
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overrun_r <= 1'b0;
    end else if (holdWord & pending_r) begin
      overrun_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Host handshake sequencer
  // ****************************************************************

  // Next state of the interrupt, request and acknowledge sequence
  always_comb begin
    hsState_nxt = hsState_r;
    unique case (hsState_r)
      input_converter_pkg::HS_IDLE: begin
        if (fresh_r) begin
          hsState_nxt = input_converter_pkg::HS_WAIT_IE;
        end
      end
      input_converter_pkg::HS_WAIT_IE: begin
        if (ieLvl) begin
          hsState_nxt = input_converter_pkg::HS_INTR;
        end
      end
      input_converter_pkg::HS_INTR: begin
        if (iackLvl) begin
          hsState_nxt = input_converter_pkg::HS_REQ;
        end
      end
      input_converter_pkg::HS_REQ: begin
        if (ackDone) begin
          hsState_nxt = input_converter_pkg::HS_ACK_LOW;
        end
      end
      input_converter_pkg::HS_ACK_LOW: begin
        // Wait for the acknowledge to fall so one pulse never counts twice
        if (~rackLvl) begin
          hsState_nxt = input_converter_pkg::HS_IDLE;
        end
      end
    endcase
  end

  // Sequencer state; reset returns it to idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hsState_r <= input_converter_pkg::HS_IDLE;
    end else begin
      hsState_r <= hsState_nxt;
    end
  end

  // ****************************************************************
  // Host outputs
  // ****************************************************************

  logic hostIntr_r;
  logic wordReadyRequest_r;
  wire intr_nxt;
  wire req_nxt;
  wire nextIsIntr;
  wire nextIsReq;

  // Outputs follow the next state so they move on the same edge as the sequencer
  assign nextIsIntr = (hsState_nxt == input_converter_pkg::HS_INTR);
  assign nextIsReq = (hsState_nxt == input_converter_pkg::HS_REQ);
  // Both lines fall together on the acknowledge
  assign intr_nxt = nextIsIntr | nextIsReq;
  assign req_nxt = nextIsReq;

  // Registered host lines; reset drops both
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hostIntr_r <= 1'b0;
      wordReadyRequest_r <= 1'b0;
    end else begin
      hostIntr_r <= intr_nxt;
      wordReadyRequest_r <= req_nxt;
    end
  end

  assign hostIntr = hostIntr_r;
  assign wordReadyRequest = wordReadyRequest_r;
  assign hostData = store2_r;
  assign wordOverrun = overrun_r;

endmodule : input_converter
`default_nettype wire

// ### bench/input_converter_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host handshake checks
// ****
module input_converter_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hostIntrEnable,
  input wire logic hostIntrAck,
  input wire logic hostReadAck,
  input wire logic hostIntr,
  input wire logic wordReadyRequest,
  input wire logic [input_converter_pkg::WORD_W-1:0] hostData
);
  // One domain; reset masks every check
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Interrupt only after enable has settled
  property p_intr_en;
    $rose(hostIntr) |-> $past(hostIntrEnable, 2);
  endproperty
  a_intr_en: assert property (p_intr_en) else $error("interrupt without enable");
  property p_req_ack;
    $rose(wordReadyRequest) |-> $past(hostIntrAck, 2);
  endproperty
  a_req_ack: assert property (p_req_ack) else $error("request without interrupt ack");
  property p_req_intr;
    wordReadyRequest |-> hostIntr;
  endproperty
  a_req_intr: assert property (p_req_intr) else $error("request outside interrupt");
  // Drop within the sync delay plus one register
  property p_drop_ack;
    $rose(hostReadAck) && wordReadyRequest |-> ##[1:6] (!hostIntr && !wordReadyRequest);
  endproperty
  a_drop_ack: assert property (p_drop_ack) else $error("no drop after read ack");
  property p_drop_both;
    $fell(hostIntr) |-> !wordReadyRequest;
  endproperty
  a_drop_both: assert property (p_drop_both) else $error("request outlived interrupt");
  property p_no_early;
    $fell(hostIntr) |-> $past(hostReadAck);
  endproperty
  a_no_early: assert property (p_no_early) else $error("interrupt dropped without ack");
  // Word on the lines frozen during readout
  property p_frozen;
    hostIntr && $past(hostIntr) |-> $stable(hostData);
  endproperty
  a_frozen: assert property (p_frozen) else $error("data moved during readout");
  property p_new_word;
    $changed(hostData) && hostIntrEnable |-> ##[1:40] hostIntr;
  endproperty
  a_new_word: assert property (p_new_word) else $error("new word without interrupt");
endmodule : input_converter_chk

bind input_converter input_converter_chk u_input_converter_chk (.clk(clk), .sys_rst(sys_rst),
  .hostIntrEnable(hostIntrEnable), .hostIntrAck(hostIntrAck), .hostReadAck(hostReadAck),
  .hostIntr(hostIntr), .wordReadyRequest(wordReadyRequest), .hostData(hostData));
`default_nettype wire

// ### bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host parallel input channel
// ****
module host_model (
  input wire logic clk,
  input var int ackDelay,
  input wire logic hostIntr,
  input wire logic wordReadyRequest,
  input wire logic [input_converter_pkg::WORD_W-1:0] hostData,
  output var logic intrAck,
  output var logic readAck
);
  logic [input_converter_pkg::WORD_W-1:0] got [$];

  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick

  // Acks held until the device drops its request; slow mode stalls before each ack is raised
  initial begin
    intrAck = 1'b0;
    readAck = 1'b0;
    forever begin
      do tick(); while (hostIntr !== 1'b1);
      repeat (ackDelay) tick();
      intrAck = 1'b1;
      do tick(); while (wordReadyRequest !== 1'b1);
      repeat (ackDelay) tick();
      got.push_back(hostData);
      readAck = 1'b1;
      do tick(); while (wordReadyRequest !== 1'b0);
      readAck = 1'b0;
      intrAck = 1'b0;
    end
  end
endmodule : host_model
`default_nettype wire

// ### bench/input_converter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module input_converter_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] sel = 2'h0;
  logic [2:0] srcData = 3'h0;
  logic [2:0] srcClk = 3'h0;
  logic ieLevel = 1'b1;
  int ackDelay = 0;
  logic intrAck, readAck, hostIntr, wordReadyRequest, wordOverrun;
  logic [input_converter_pkg::WORD_W-1:0] hostData;
  logic [29:0] pat [3] = '{30'h2C3A5E91, 30'h15A0F00F, 30'h20000001};
  int fail_count = 0;
  int tests_run = 0;

  always #12.5 clk = ~clk;

  input_converter u_input_converter (.clk(clk), .sys_rst(sys_rst), .sourceSelect(sel),
    .cmdDecoderData(srcData[0]), .cmdDecoderClk(srcClk[0]), .sigProcData(srcData[1]),
    .sigProcClk(srcClk[1]), .ifaceUnitData(srcData[2]), .ifaceUnitClk(srcClk[2]),
    .hostIntrEnable(ieLevel), .hostIntrAck(intrAck), .hostReadAck(readAck), .hostIntr(hostIntr),
    .wordReadyRequest(wordReadyRequest), .hostData(hostData), .wordOverrun(wordOverrun));
  host_model u_host_model (.clk(clk), .ackDelay(ackDelay), .hostIntr(hostIntr),
    .wordReadyRequest(wordReadyRequest), .hostData(hostData), .intrAck(intrAck), .readAck(readAck));

  // ****
  // Shared tasks
  // ****
  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick

  task automatic check(input string what, input logic [29:0] seen, input logic [29:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask : check

  // MSB first at 200 ns; unselected sources carry the inverse word
  task automatic sendWord(input logic [29:0] w);
    tick();
    for (int i = 29; i >= 0; i--) begin
      srcData = {3{~w[i]}} ^ (3'h1 << sel);
      #100 srcClk = 3'h7;
      #100 srcClk = 3'h0;
    end
    srcData = ~srcData; // Line left behind, not its last bit
  endtask : sendWord

  // Bounded wait for the host to take a word
  task automatic takeWord(output logic [29:0] w);
    int n;
    n = 0;
    while (u_host_model.got.size() == 0 && n < 5000) begin
      tick();
      n++;
    end
    w = (u_host_model.got.size() == 0) ? 30'hXXXXXXXX : u_host_model.got.pop_front();
  endtask : takeWord

  // ****
  // Scenarios
  // ****
  task automatic t_sources;
    logic [29:0] got;
    for (int s = 0; s < 3; s++) begin
      sel = s[1:0];
      sendWord(pat[s]);
      takeWord(got);
      check("srcWord", got, pat[s]);
      check("dataLines", hostData, pat[s]);
    end
    sel = 2'h3;
    sendWord(30'h3FFFFFFF);
    repeat (40) tick();
    check("quietIntr", {29'h0, hostIntr}, 30'h0);
    sel = 2'h0;
    $display("done sources");
  endtask : t_sources

  task automatic t_enable;
    logic [29:0] got;
    ieLevel = 1'b0;
    sendWord(pat[1]);
    repeat (40) tick();
    check("intrHeld", {29'h0, hostIntr}, 30'h0);
    check("store2", hostData, pat[1]);
    ieLevel = 1'b1;
    takeWord(got);
    check("lateWord", got, pat[1]);
    $display("done enable");
  endtask : t_enable

  // Slow host: second word held back, third overwrites it
  task automatic t_held;
    logic [29:0] got;
    ackDelay = 600;
    sendWord(pat[0]);
    sendWord(pat[1]);
    check("frozen", hostData, pat[0]);
    sendWord(pat[2]);
    takeWord(got);
    check("first", got, pat[0]);
    takeWord(got);
    check("newest", got, pat[2]);
    check("overrun", {29'h0, wordOverrun}, 30'h1);
    ackDelay = 0;
    $display("done held");
  endtask : t_held

  task automatic t_reset;
    sys_rst = 1'b1;
    repeat (4) tick();
    sys_rst = 1'b0;
    tick();
    check("rstData", hostData, 30'h0);
    check("rstFlags", {27'h0, hostIntr, wordReadyRequest, wordOverrun}, 30'h0);
    $display("done reset");
  endtask : t_reset

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // Main sequence after ten reset cycles
  initial begin
    repeat (10) tick();
    sys_rst = 1'b0;
    tick();
    t_sources();
    t_enable();
    t_held();
    t_reset();
    results();
  end

  // Run needs under 8000 cycles; generous margin
  initial begin
    #(25 * 20000);
    fail_count++;
    results();
  end
endmodule : input_converter_tb
`default_nettype wire
